// ### hw/isx_pkg.sv
// How it works
// - Indexed pair move adds offsets to frame pointer.
// - Pair move: two words, read then write.
// - Pair move never writes pc or return-top bytes.
// - Source on indirect register reads as zero.
// - Destination on indirect register makes no write.
// - Push stores literal at frame pointer address.
// - Push then decrements frame pointer by one.
// - Opcode 1111 1010 decodes as push literal.
// - Pointer subtract takes literal from selected pointer.
// - Opcode 1110 1001 decodes pointer subtract fields.
// - Select value three means frame shrink return.
// - Shrink return subtracts, loads pc, two cycles.
// - Extended set also enables indexed offset mode.
// - Disabled: access bank or bank select register.
// - Enabled, access, operand up to 5Fh is offset.
// - Zero frame pointer gives normal access addresses.
// - Destination select keeps its normal meaning.
// - Destination zero goes to working register.
// - Extended set disabled by default configuration.
package isx_pkg;
    localparam logic [7:0]  OPC_PUSH      = 8'hfa;
    localparam logic [7:0]  OPC_PSUB      = 8'he9;
    localparam logic [7:0]  OPC_MOVE_HI   = 8'heb;
    localparam logic [3:0]  OPC_MOVE_W2   = 4'hf;
    localparam logic [1:0]  SEL_FRAME     = 2'h2;
    localparam logic [1:0]  SEL_RETURN    = 2'h3;
    localparam logic [7:0]  OFFSET_LIMIT  = 8'h5f;
    localparam logic [11:0] ACCESS_HI_BASE = 12'hf00;
    localparam logic [11:0] ADDR_PC_LOW   = 12'hff9;
    localparam logic [11:0] ADDR_RET_LOW  = 12'hffd;
    localparam logic [11:0] ADDR_RET_HIGH = 12'hffe;
    localparam logic [11:0] ADDR_RET_UP   = 12'hfff;
    localparam logic [11:0] ADDR_INDF_A   = 12'hfef;
    localparam logic [11:0] ADDR_INDF_B   = 12'hfe7;
    localparam logic [11:0] ADDR_INDF_C   = 12'hfdf;
    localparam logic [11:0] ADDR_INDF_D   = 12'hfee;
    localparam logic [11:0] ADDR_INDF_E   = 12'hfe6;
    localparam logic [11:0] ADDR_INDF_F   = 12'hfde;
    localparam logic [11:0] ADDR_INDF_G   = 12'hfed;
    localparam logic [11:0] ADDR_INDF_H   = 12'hfe5;
    localparam logic [11:0] ADDR_INDF_I   = 12'hfdd;
    localparam logic [11:0] ADDR_INDF_J   = 12'hfec;
    localparam logic [11:0] ADDR_INDF_K   = 12'hfe4;
    localparam logic [11:0] ADDR_INDF_L   = 12'hfdc;
    localparam logic [11:0] ADDR_INDF_M   = 12'hfeb;
    localparam logic [11:0] ADDR_INDF_N   = 12'hfe3;
    localparam logic [11:0] ADDR_INDF_O   = 12'hfdb;
    localparam logic [11:0] PTR_RESET     = 12'h000;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    // Avalon register map, word aligned byte addresses.
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_PTR0      = 4'h4;
    localparam logic [3:0]  REG_PTR1      = 4'h8;
    localparam logic [3:0]  REG_PTR2      = 4'hc;
    localparam int          CTRL_EXT_BIT  = 0;
    localparam int          CTRL_BANK_LSB = 8;

    typedef enum logic [2:0] {
        ISX_OP_NONE,
        ISX_OP_PUSH,
        ISX_OP_PSUB,
        ISX_OP_RET,
        ISX_OP_MOVE
    } isx_op_t;

    // Memory request toward the core data memory.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } isx_mem_req_t;
endpackage

// ### hw/isx_exec.sv
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
module isx_exec (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_instr_valid,
    input  wire logic [15:0]           i_instr,
    input  wire logic [7:0]            i_mem_rdata,
    input  wire logic [20:0]           i_return_stack_top,
    input  wire logic [7:0]            i_std_operand,
    input  wire logic                  i_std_access_sel,
    input  wire logic                  i_std_dest_sel,
    input  wire logic [3:0]            i_avs_address,
    input  wire logic                  i_avs_read,
    input  wire logic                  i_avs_write,
    input  wire logic [31:0]           i_avs_writedata,
    output logic [31:0]                o_avs_readdata,
    output logic                       o_avs_waitrequest,
    output isx_pkg::isx_mem_req_t      o_mem_req,
    output logic                       o_pc_load,
    output logic [20:0]                o_pc_value,
    output logic                       o_busy,
    output logic                       o_ext_decoded,
    output logic [11:0]                o_std_addr,
    output logic                       o_std_to_wreg
);
    logic [11:0]          ptr [0:2];
    logic                 extended_set_enable;
    logic [3:0]           bank_select_register;
    logic                 second_cycle;
    isx_pkg::isx_op_t     pend_op;
    logic [11:0]          src_addr;
    logic [7:0]           move_data;
    logic                 avs_done;
    isx_pkg::isx_op_t     dec_op;
    logic [11:0]          frame_ptr;
    logic [11:0]          dst_addr;

    // Every check below runs on the system clock and is off while reset is held.
    default clocking isx_cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    // Tells whether an address is one of the indirect access registers.
    function automatic logic is_indirect(input logic [11:0] a);
        is_indirect = (a == isx_pkg::ADDR_INDF_A) || (a == isx_pkg::ADDR_INDF_B) || (a == isx_pkg::ADDR_INDF_C) ||
                      (a == isx_pkg::ADDR_INDF_D) || (a == isx_pkg::ADDR_INDF_E) || (a == isx_pkg::ADDR_INDF_F) ||
                      (a == isx_pkg::ADDR_INDF_G) || (a == isx_pkg::ADDR_INDF_H) || (a == isx_pkg::ADDR_INDF_I) ||
                      (a == isx_pkg::ADDR_INDF_J) || (a == isx_pkg::ADDR_INDF_K) || (a == isx_pkg::ADDR_INDF_L) ||
                      (a == isx_pkg::ADDR_INDF_M) || (a == isx_pkg::ADDR_INDF_N) || (a == isx_pkg::ADDR_INDF_O);
    endfunction

    // Tells whether an address is the pc low byte or a return-top byte.
    function automatic logic is_protected(input logic [11:0] a);
        is_protected = (a == isx_pkg::ADDR_PC_LOW) || (a == isx_pkg::ADDR_RET_LOW) ||
                       (a == isx_pkg::ADDR_RET_HIGH) || (a == isx_pkg::ADDR_RET_UP);
    endfunction

    // Adds a 7-bit offset to the frame pointer within the 4096-byte space.
    function automatic logic [11:0] frame_offset(input logic [11:0] base, input logic [6:0] off);
        frame_offset = base + {5'h00, off};
    endfunction

    assign frame_ptr = ptr[isx_pkg::SEL_FRAME];
    assign o_busy    = second_cycle;
    assign dst_addr  = frame_offset(frame_ptr, i_instr[6:0]);

    // Decodes the extended opcodes; none exist while the set is disabled.
    always_comb begin
        dec_op = isx_pkg::ISX_OP_NONE;
        if (i_instr_valid && !second_cycle && extended_set_enable) begin
            if (i_instr[15:8] == isx_pkg::OPC_PUSH) begin
                dec_op = isx_pkg::ISX_OP_PUSH;
            end else if (i_instr[15:8] == isx_pkg::OPC_PSUB) begin
                dec_op = (i_instr[7:6] == isx_pkg::SEL_RETURN) ? isx_pkg::ISX_OP_RET
                                                              : isx_pkg::ISX_OP_PSUB;
            end else if (i_instr[15:8] == isx_pkg::OPC_MOVE_HI && i_instr[7]) begin
                dec_op = isx_pkg::ISX_OP_MOVE;
            end
        end
    end

    // Standard byte and bit operand resolution.
    always_comb begin
        if (extended_set_enable && !i_std_access_sel && i_std_operand <= isx_pkg::OFFSET_LIMIT) begin
            o_std_addr = frame_ptr + {4'h0, i_std_operand};
        end else if (!i_std_access_sel) begin
            o_std_addr = (i_std_operand[7] ? isx_pkg::ACCESS_HI_BASE : 12'h000) | {4'h0, i_std_operand};
        end else begin
            o_std_addr = {bank_select_register, i_std_operand};
        end
        o_std_to_wreg = !i_std_dest_sel;
    end

    // Two-cycle sequencing for the pair move and the shrink return.
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            second_cycle <= 1'b0;
            pend_op      <= isx_pkg::ISX_OP_NONE;
            src_addr     <= isx_pkg::PTR_RESET;
        end else if (second_cycle) begin
            if (pend_op != isx_pkg::ISX_OP_MOVE || i_instr_valid) begin
                second_cycle <= 1'b0;
                pend_op      <= isx_pkg::ISX_OP_NONE;
            end
        end else if (dec_op == isx_pkg::ISX_OP_MOVE || dec_op == isx_pkg::ISX_OP_RET) begin
            second_cycle <= 1'b1;
            pend_op      <= dec_op;
            src_addr     <= dst_addr;
        end
    end

    // Captures the source byte read in the first move cycle.
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            move_data <= isx_pkg::BYTE_ZERO;
        end else if (second_cycle && pend_op == isx_pkg::ISX_OP_MOVE && !o_mem_req.wr && !o_mem_req.rd) begin
            move_data <= move_data;
        end else if (dec_op == isx_pkg::ISX_OP_MOVE) begin
            move_data <= is_indirect(dst_addr) ? isx_pkg::BYTE_ZERO : i_mem_rdata;
        end
    end

    // Memory requests: source read, destination write, literal push.
    always_comb begin
        o_mem_req = '0;
        if (dec_op == isx_pkg::ISX_OP_MOVE) begin
            o_mem_req.rd   = !is_indirect(dst_addr);
            o_mem_req.addr = dst_addr;
        end else if (dec_op == isx_pkg::ISX_OP_PUSH) begin
            o_mem_req.wr    = 1'b1;
            o_mem_req.addr  = frame_ptr;
            o_mem_req.wdata = i_instr[7:0];
        end else if (second_cycle && pend_op == isx_pkg::ISX_OP_MOVE && i_instr_valid &&
                     i_instr[15:12] == isx_pkg::OPC_MOVE_W2) begin
            o_mem_req.addr  = dst_addr;
            o_mem_req.wdata = move_data;
            o_mem_req.wr    = !is_indirect(dst_addr) && !is_protected(dst_addr);
        end
    end

    // Program counter reload for the shrink return.
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_pc_load  <= 1'b0;
            o_pc_value <= 21'h000000;
        end else begin
            o_pc_load <= (dec_op == isx_pkg::ISX_OP_RET);
            if (dec_op == isx_pkg::ISX_OP_RET) begin
                o_pc_value <= i_return_stack_top;
            end
        end
    end

    // Decode indication pulse, registered.
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_ext_decoded <= 1'b0;
        end else begin
            o_ext_decoded <= (dec_op != isx_pkg::ISX_OP_NONE);
        end
    end

    // Pointer file: push decrement, subtract, and software writes.
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            for (int i = 0; i < 3; i++) begin
                ptr[i] <= isx_pkg::PTR_RESET;
            end
        end else if (dec_op == isx_pkg::ISX_OP_PUSH) begin
            ptr[isx_pkg::SEL_FRAME] <= frame_ptr - 12'h001;
        end else if (dec_op == isx_pkg::ISX_OP_PSUB) begin
            ptr[i_instr[7:6]] <= ptr[i_instr[7:6]] - {6'h00, i_instr[5:0]};
        end else if (dec_op == isx_pkg::ISX_OP_RET) begin
            ptr[isx_pkg::SEL_FRAME] <= frame_ptr - {6'h00, i_instr[5:0]};
        end else if (i_avs_write && !o_avs_waitrequest) begin
            case (i_avs_address)
                isx_pkg::REG_PTR0: ptr[0] <= i_avs_writedata[11:0];
                isx_pkg::REG_PTR1: ptr[1] <= i_avs_writedata[11:0];
                isx_pkg::REG_PTR2: ptr[2] <= i_avs_writedata[11:0];
                default: ;
            endcase
        end
    end

    // Control register: extended set enable and bank select.
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            extended_set_enable  <= 1'b0;
            bank_select_register <= 4'h0;
        end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == isx_pkg::REG_CTRL) begin
            extended_set_enable  <= i_avs_writedata[isx_pkg::CTRL_EXT_BIT];
            bank_select_register <= i_avs_writedata[isx_pkg::CTRL_BANK_LSB +: 4];
        end
    end

    // Avalon slave: one wait cycle, answer on the second cycle.
    // Pointer writes wait while an extended op would also update pointers.
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) &&
                               (!avs_done || (i_avs_write && dec_op != isx_pkg::ISX_OP_NONE));
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            avs_done       <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end else if ((i_avs_read || i_avs_write) && !avs_done) begin
            avs_done <= 1'b1;
            case (i_avs_address)
                isx_pkg::REG_CTRL: o_avs_readdata <= {20'h00000, bank_select_register, 7'h00, extended_set_enable};
                isx_pkg::REG_PTR0: o_avs_readdata <= {20'h00000, ptr[0]};
                isx_pkg::REG_PTR1: o_avs_readdata <= {20'h00000, ptr[1]};
                isx_pkg::REG_PTR2: o_avs_readdata <= {20'h00000, ptr[2]};
                default:           o_avs_readdata <= 32'h00000000;
            endcase
        end else if (!o_avs_waitrequest) begin
            avs_done <= 1'b0;
        end
    end

    // Checks on push and pointer subtract.
    push_store_a: assert property (dec_op == isx_pkg::ISX_OP_PUSH |->
        o_mem_req.wr && o_mem_req.addr == frame_ptr)
        else $error("push did not store at frame pointer");
    push_decrement_a: assert property (dec_op == isx_pkg::ISX_OP_PUSH |=>
        frame_ptr == $past(frame_ptr) - 12'h001)
        else $error("push did not decrement frame pointer by one");
    push_single_a: assert property (dec_op == isx_pkg::ISX_OP_PUSH |=>
        !o_busy)
        else $error("push did not finish in one cycle");
    sub_result_a: assert property (dec_op == isx_pkg::ISX_OP_PSUB &&
        i_instr[7:6] == isx_pkg::SEL_FRAME
        |=> frame_ptr == $past(frame_ptr) - {6'h00, $past(i_instr[5:0])})
        else $error("pointer subtract result wrong");
    sub_other_a: assert property (dec_op == isx_pkg::ISX_OP_PSUB &&
        i_instr[7:6] != isx_pkg::SEL_FRAME |=> frame_ptr == $past(frame_ptr))
        else $error("subtract on another pointer moved the frame pointer");
    sub_single_a: assert property (dec_op == isx_pkg::ISX_OP_PSUB |=>
        !o_busy)
        else $error("pointer subtract did not finish in one cycle");

    // Checks on the shrink return.
    ret_pc_load_a: assert property (dec_op == isx_pkg::ISX_OP_RET |=>
        o_pc_load && o_busy ##1 !o_busy)
        else $error("shrink return did not take two cycles");
    ret_pc_value_a: assert property (dec_op == isx_pkg::ISX_OP_RET |=>
        o_pc_value == $past(i_return_stack_top))
        else $error("shrink return loaded a wrong pc");
    ret_frame_a: assert property (dec_op == isx_pkg::ISX_OP_RET |=>
        frame_ptr == $past(frame_ptr) - {6'h00, $past(i_instr[5:0])})
        else $error("shrink return did not shrink the frame pointer");
    ret_quiet_a: assert property (dec_op == isx_pkg::ISX_OP_RET |=>
        o_mem_req == '0)
        else $error("second cycle of shrink return was not idle");

    // Checks on the pair move.
    move_read_a: assert property (dec_op == isx_pkg::ISX_OP_MOVE &&
        !is_indirect(dst_addr) |-> o_mem_req.rd && o_mem_req.addr == dst_addr)
        else $error("pair move source read wrong");
    move_busy_a: assert property (dec_op == isx_pkg::ISX_OP_MOVE |=>
        o_busy)
        else $error("pair move did not enter its second cycle");
    move_source_a: assert property (dec_op == isx_pkg::ISX_OP_MOVE &&
        is_indirect(dst_addr) |=> move_data == isx_pkg::BYTE_ZERO)
        else $error("indirect source not read as zero");
    move_write_a: assert property (second_cycle && pend_op == isx_pkg::ISX_OP_MOVE &&
        o_mem_req.wr |-> o_mem_req.addr == dst_addr && o_mem_req.wdata == move_data)
        else $error("pair move destination write wrong");
    move_protect_a: assert property (second_cycle && pend_op == isx_pkg::ISX_OP_MOVE &&
        o_mem_req.wr |-> !is_protected(o_mem_req.addr))
        else $error("pair move wrote a pc or return-top byte");
    move_nop_a: assert property (second_cycle && pend_op == isx_pkg::ISX_OP_MOVE &&
        is_indirect(dst_addr) |-> !o_mem_req.wr)
        else $error("pair move wrote through an indirect register");

    // Checks on decode enable and operand resolution.
    no_ext_off_a: assert property (!extended_set_enable |->
        dec_op == isx_pkg::ISX_OP_NONE)
        else $error("extended op decoded while disabled");
    no_ext_addr_a: assert property (!extended_set_enable && !i_std_access_sel &&
        !i_std_operand[7] |-> o_std_addr == {4'h0, i_std_operand})
        else $error("operand offset applied while disabled");
    offset_mode_a: assert property (extended_set_enable && !i_std_access_sel &&
        i_std_operand <= isx_pkg::OFFSET_LIMIT |-> o_std_addr == frame_ptr + {4'h0, i_std_operand})
        else $error("indexed offset address wrong");
    bank_sel_a: assert property (i_std_access_sel |->
        o_std_addr == {bank_select_register, i_std_operand})
        else $error("banked operand address wrong");
    dest_sel_a: assert property (
        o_std_to_wreg == !i_std_dest_sel)
        else $error("destination select wrong");
    ext_write_a: assert property (i_avs_write && !o_avs_waitrequest &&
        i_avs_address == isx_pkg::REG_CTRL
        |=> extended_set_enable == $past(i_avs_writedata[isx_pkg::CTRL_EXT_BIT]))
        else $error("extended set enable not taken from the control write");

    // Check on the register bus wait cycle.
    avs_first_wait_a: assert property ((i_avs_read || i_avs_write) && !avs_done |->
        o_avs_waitrequest)
        else $error("bus access answered without its wait cycle");

    push_seen_c: cover property (dec_op == isx_pkg::ISX_OP_PUSH);
    psub_seen_c: cover property (dec_op == isx_pkg::ISX_OP_PSUB);
    move_done_c: cover property (dec_op == isx_pkg::ISX_OP_MOVE ##1 o_mem_req.wr);
    ret_seen_c: cover property (o_pc_load);
    offset_seen_c: cover property (extended_set_enable && !i_std_access_sel &&
        i_std_operand <= isx_pkg::OFFSET_LIMIT);
endmodule

// ### testbench/isx_core_model.sv
`timescale 1ns/1ps
module isx_core_model #(
    parameter logic [20:0] RTOP = 21'h01a2b
) (
    input  wire logic                  i_clk_sys,
    input  wire isx_pkg::isx_mem_req_t i_mem_req,
    output logic [7:0]                 o_rdata,
    output logic [20:0]                o_return_top,
    output int                         o_bad_writes
);
    logic [7:0] mem [0:4095];
    logic [7:0] last_rd;

    // Return stack top stays at one known value so a load is easy to recognise.
    assign o_return_top = RTOP;

    // Memory starts with each byte equal to its low address bits.
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0];
        end
        o_bad_writes = 0;
        last_rd = 8'h00;
    end

    // Read data answers in the same cycle; when idle it shows the inverse of the last byte.
    always_comb begin
        o_rdata = i_mem_req.rd ? mem[i_mem_req.addr] : ~last_rd;
    end

    // Writes land at the clock edge; a write to the pc or return-top bytes is counted as a fault.
    always @(posedge i_clk_sys) begin
        if (i_mem_req.rd) begin
            last_rd <= mem[i_mem_req.addr];
        end
        if (i_mem_req.wr) begin
            mem[i_mem_req.addr] <= i_mem_req.wdata;
            if (i_mem_req.addr >= 12'hffd || i_mem_req.addr == 12'hff9) begin
                o_bad_writes <= o_bad_writes + 1;
            end
        end
    end
endmodule

// ### testbench/indexed_stack_instruction_exec_tb.sv
`timescale 1ns/1ps
module indexed_stack_instruction_exec_tb;
    localparam logic [20:0] RTOP = 21'h01a2b;
    logic                  i_clk_sys, i_reset_n, i_instr_valid, i_std_access_sel, i_std_dest_sel;
    logic                  i_avs_read, i_avs_write;
    logic [15:0]           i_instr;
    logic [7:0]            i_mem_rdata, i_std_operand;
    logic [20:0]           i_return_stack_top;
    logic [3:0]            i_avs_address;
    logic [31:0]           i_avs_writedata, o_avs_readdata, rd;
    logic                  o_avs_waitrequest, o_pc_load, o_busy, o_ext_decoded, o_std_to_wreg;
    logic [20:0]           o_pc_value;
    logic [11:0]           o_std_addr;
    isx_pkg::isx_mem_req_t o_mem_req, req1, req2;
    logic                  p_load, p_busy, p_ext;
    int                    errors, compares, bad_wr;
    logic [6:0]            zd_list [5] = '{7'h19, 7'h1d, 7'h1e, 7'h1f, 7'h0f};

    isx_exec dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .i_mem_rdata(i_mem_rdata), .i_return_stack_top(i_return_stack_top),
        .i_std_operand(i_std_operand), .i_std_access_sel(i_std_access_sel), .i_std_dest_sel(i_std_dest_sel),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .o_mem_req(o_mem_req), .o_pc_load(o_pc_load),
        .o_pc_value(o_pc_value), .o_busy(o_busy), .o_ext_decoded(o_ext_decoded), .o_std_addr(o_std_addr),
        .o_std_to_wreg(o_std_to_wreg));
    isx_core_model #(.RTOP(RTOP)) core (.i_clk_sys(i_clk_sys), .i_mem_req(o_mem_req), .o_rdata(i_mem_rdata),
        .o_return_top(i_return_stack_top), .o_bad_writes(bad_wr));

    // Clock at 200 MHz.
    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    task automatic print_verdict();
        $display("Totals: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One Avalon access; the request holds until waitrequest is seen low.
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        i_avs_address <= a;
        i_avs_writedata <= wd;
        i_avs_read <= !wr;
        i_avs_write <= wr;
        do begin
            @(negedge i_clk_sys);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            errors++;
            print_verdict();
        end
        rd = o_avs_readdata;
        @(posedge i_clk_sys);
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask

    // Issues one instruction, or both words of a pair move, and samples the outputs.
    task automatic run(input logic [15:0] w1, input logic two, input logic [15:0] w2);
        @(posedge i_clk_sys);
        i_instr <= w1;
        i_instr_valid <= 1'b1;
        @(negedge i_clk_sys);
        req1 = o_mem_req;
        @(posedge i_clk_sys);
        if (two) begin
            i_instr <= w2;
            @(negedge i_clk_sys);
            req2 = o_mem_req;
            @(posedge i_clk_sys);
        end
        i_instr_valid <= 1'b0;
        @(negedge i_clk_sys);
        p_load = o_pc_load;
        p_busy = o_busy;
        p_ext = o_ext_decoded;
    endtask

    task automatic std(input logic [7:0] op, input logic a, input logic [11:0] exp);
        @(posedge i_clk_sys);
        i_std_operand <= op;
        i_std_access_sel <= a;
        @(negedge i_clk_sys);
        chk("std_addr", {20'h0, o_std_addr}, {20'h0, exp});
    endtask

    task automatic t_reset();
        av(1'b0, isx_pkg::REG_CTRL, 32'h0);
        chk("ctrl_reset", rd, 32'h0);
        av(1'b1, 4'h2, 32'hffff_ffff);
        av(1'b0, 4'h2, 32'h0);
        chk("unmapped", rd, 32'h0);
        av(1'b1, isx_pkg::REG_CTRL, 32'h0000_0300);
        run(16'hfa55, 1'b0, 16'h0);
        chk("push_off_wr", {31'h0, req1.wr}, 32'h0);
        chk("push_off_dec", {31'h0, p_ext}, 32'h0);
        std(8'h20, 1'b0, 12'h020);
        std(8'h20, 1'b1, 12'h320);
        $display("test reset done");
    endtask

    task automatic t_push(input logic [11:0] p);
        av(1'b1, isx_pkg::REG_CTRL, 32'h1);
        av(1'b1, isx_pkg::REG_PTR2, {20'h0, p});
        run(16'hfa08, 1'b0, 16'h0);
        chk("push_req", {req1.wr, req1.addr, req1.wdata}, {1'b1, p, 8'h08});
        chk("push_dec", {p_ext, p_busy}, 32'h2);
        av(1'b0, isx_pkg::REG_PTR2, 32'h0);
        chk("push_ptr", rd, {20'h0, p - 12'h1});
        $display("test push done");
    endtask

    task automatic t_psub();
        for (int s = 0; s < 3; s++) begin
            av(1'b1, 4'(4 * s + 4), 32'h3ff);
            run({8'he9, 2'(s), (s == 2) ? 6'h3f : 6'h23}, 1'b0, 16'h0);
            av(1'b0, 4'(4 * s + 4), 32'h0);
            chk("psub_ptr", rd, (s == 2) ? 32'h3c0 : 32'h3dc);
            chk("psub_busy", {31'h0, p_busy}, 32'h0);
        end
        $display("test subtract done");
    endtask

    task automatic t_ret();
        av(1'b1, isx_pkg::REG_PTR0, 32'h111);
        av(1'b1, isx_pkg::REG_PTR2, 32'h3ff);
        run(16'he9e3, 1'b0, 16'h0);
        chk("ret_load", {p_load, p_busy}, 32'h3);
        chk("ret_pc", {11'h0, o_pc_value}, {11'h0, RTOP});
        av(1'b0, isx_pkg::REG_PTR2, 32'h0);
        chk("ret_ptr", rd, 32'h3dc);
        av(1'b0, isx_pkg::REG_PTR0, 32'h0);
        chk("ret_other", rd, 32'h111);
        $display("test return done");
    endtask

    task automatic t_move();
        av(1'b1, isx_pkg::REG_PTR2, 32'h080);
        core.mem[12'h085] = 8'h33;
        run(16'heb85, 1'b1, 16'hff06);
        chk("move_rd", {req1.rd, req1.addr}, {1'b1, 12'h085});
        chk("move_wr", {req2.wr, req2.addr, req2.wdata}, {1'b1, 12'h086, 8'h33});
        av(1'b1, isx_pkg::REG_PTR2, 32'hfe0);
        core.mem[12'hfef] = 8'h5a;
        run(16'heb8f, 1'b1, 16'hf010);
        chk("move_src_ind", {req2.wr, req2.wdata}, {1'b1, 8'h00});
        foreach (zd_list[i]) begin
            run(16'heb90, 1'b1, {9'h1e0, zd_list[i]});
            chk("move_prot", {31'h0, req2.wr}, 32'h0);
        end
        chk("prot_writes", bad_wr, 32'h0);
        $display("test move done");
    endtask

    task automatic t_ilo();
        av(1'b1, isx_pkg::REG_CTRL, 32'h0000_0301);
        av(1'b1, isx_pkg::REG_PTR2, 32'ha00);
        std(8'h2c, 1'b0, 12'ha2c);
        std(8'h5f, 1'b0, 12'ha5f);
        std(8'h60, 1'b0, 12'h060);
        std(8'h2c, 1'b1, 12'h32c);
        @(posedge i_clk_sys);
        i_std_dest_sel <= 1'b1;
        std(8'h2c, 1'b0, 12'ha2c);
        chk("to_wreg1", {31'h0, o_std_to_wreg}, 32'h0);
        @(posedge i_clk_sys);
        i_std_dest_sel <= 1'b0;
        av(1'b1, isx_pkg::REG_PTR2, 32'h0);
        std(8'h2c, 1'b0, 12'h02c);
        chk("to_wreg0", {31'h0, o_std_to_wreg}, 32'h1);
        $display("test offset mode done");
    endtask

    // Main sequence: reset for six cycles, then every scenario in turn.
    initial begin
        errors = 0;
        compares = 0;
        i_reset_n = 1'b0;
        {i_instr_valid, i_std_access_sel, i_std_dest_sel, i_avs_read, i_avs_write} = 5'h0;
        i_instr = 16'h0;
        i_std_operand = 8'h0;
        i_avs_address = 4'h0;
        i_avs_writedata = 32'h0;
        repeat (6) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        t_reset();
        t_push(12'h1ec);
        t_push(12'h000);
        t_psub();
        t_ret();
        t_move();
        t_ilo();
        print_verdict();
    end
endmodule
